// [fbs_host_model.sv]
// Host-side serial master model driving the sequencer's frame port
`timescale 1ns/1ns
module fbs_host_model (
  input  wire logic clk,
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_mosi,
  input  wire logic spi_miso,
  input  wire logic spi_miso_oe
);
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end

  // Half of the 80 ns link period, stepped on core clock falls
  task automatic half();
    repeat (5) @(negedge clk);
  endtask : half

  task automatic sel(input logic on);
    half();
    spi_cs_n = !on;
    // A released data line must not keep showing the last bit
    if (!on) spi_mosi = !spi_mosi;
    half();
  endtask : sel

  // Mode 0, MSB first; 12.5 Mbit/s outruns every PHY byte rate
  task automatic xfer(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      spi_mosi = d[i];
      half();
      spi_sclk = 1'b1;
      q[i] = spi_miso_oe ? spi_miso : 1'bx;
      half();
      spi_sclk = 1'b0;
    end
  endtask : xfer
endmodule : fbs_host_model

// [fbs_mem.sv]
// Frame buffer storage: one write port, two registered read ports
`timescale 1ns/1ns
module fbs_mem (
  input  wire logic clk,
  fbs_mem_if.mem    mp
);
  logic [7:0] ram [fbs_pkg::FB_DEPTH];

  always_ff @(posedge clk) begin
    if (mp.we) begin
      ram[mp.waddr] <= mp.wdata;
    end
    mp.ra_data <= ram[mp.ra_addr];
    mp.rb_data <= ram[mp.rb_addr];
  end
endmodule : fbs_mem

// [fbs_mem_if.sv]
// Port bundle between the sequencer and its frame buffer memory
`timescale 1ns/1ns
interface fbs_mem_if;
  logic       we;
  logic [6:0] waddr;
  logic [7:0] wdata;
  logic [6:0] ra_addr;
  logic [7:0] ra_data;
  logic [6:0] rb_addr;
  logic [7:0] rb_data;
  modport ctl (output we, waddr, wdata, ra_addr, rb_addr, input ra_data, rb_data);
  modport mem (input we, waddr, wdata, ra_addr, rb_addr, output ra_data, rb_data);
endinterface : fbs_mem_if

// [fbs_pkg.sv]
// Constants and types for the frame buffer sequencer
package fbs_pkg;
  localparam logic [7:0] CMD_FB_RD      = 8'h20;
  localparam logic [7:0] CMD_FB_WR      = 8'h60;
  localparam logic [1:0] CMD_REG_WR_TAG = 2'h3;
  localparam logic [5:0] REG_STATE_ADDR = 6'h02;
  localparam logic [5:0] REG_RATE_ADDR  = 6'h0C;
  localparam int         STATE_CMD_LSB  = 0;
  localparam int         RATE_LSB       = 0;
  localparam logic [1:0] RATE_RST       = 2'h0;
  localparam logic [4:0] SC_TX_START    = 5'h02;
  localparam logic [4:0] SC_RX          = 5'h06;
  localparam logic [4:0] SC_OFF         = 5'h08;
  localparam logic [4:0] SC_PLL         = 5'h09;
  localparam logic [4:0] SC_AACK        = 5'h16;
  localparam logic [4:0] SC_ARET        = 5'h19;
  localparam int FB_DEPTH    = 128;
  localparam int CLK_MHZ     = 125;
  localparam int SETTLE_NS   = 16000;
  localparam int SHR_NS      = 160000;
  localparam int BYTE_NS_250 = 32000;
  localparam int BYTE_NS_500 = 16000;
  localparam int BYTE_NS_1M  = 8000;
  localparam int BYTE_NS_2M  = 4000;
  localparam int SETTLE_CYC  = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int SHR_CYC     = (SHR_NS * CLK_MHZ + 999) / 1000;
  localparam int BYTE_CYC_250 = (BYTE_NS_250 * CLK_MHZ + 999) / 1000;
  localparam int BYTE_CYC_500 = (BYTE_NS_500 * CLK_MHZ + 999) / 1000;
  localparam int BYTE_CYC_1M  = (BYTE_NS_1M * CLK_MHZ + 999) / 1000;
  localparam int BYTE_CYC_2M  = (BYTE_NS_2M * CLK_MHZ + 999) / 1000;

  typedef enum logic [2:0] {
    MODE_OFF  = 3'b000,
    MODE_PLL  = 3'b001,
    MODE_RX   = 3'b011,
    MODE_AACK = 3'b010,
    MODE_ARET = 3'b110
  } fbs_mode_t;

  typedef enum logic [1:0] {
    TX_IDLE   = 2'b00,
    TX_SETTLE = 2'b01,
    TX_SHR    = 2'b11,
    TX_DATA   = 2'b10
  } fbs_txph_t;

  typedef enum logic [1:0] {
    OP_NONE  = 2'b00,
    OP_REG   = 2'b01,
    OP_FB_RD = 2'b11,
    OP_FB_WR = 2'b10
  } fbs_op_t;
endpackage : fbs_pkg

// [fbs_seq.sv]
// Frame receive/transmit sequencer with SPI frame buffer access
`timescale 1ns/1ns
module fbs_seq #(
  parameter int unsigned SHR_CYC = fbs_pkg::SHR_CYC
) (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       spi_sclk,
  input  wire logic       spi_cs_n,
  input  wire logic       spi_mosi,
  output logic            spi_miso,
  output logic            spi_miso_oe,
  input  wire logic       sleep_transmit_pin,
  input  wire logic       rx_start_irq_en,
  input  wire logic       rx_frame_detect,
  input  wire logic       rx_byte_valid,
  input  wire logic [7:0] rx_byte,
  input  wire logic       rx_frame_end,
  output logic [7:0]      tx_byte,
  output logic            tx_byte_valid,
  output logic            tx_shr_active,
  output logic            rx_start_event,
  output logic            frame_done_event,
  output logic            buffer_underrun_event,
  output logic            fb_empty,
  output logic [2:0]      radio_mode
);
  function automatic logic [15:0] byte_cycles(input logic [1:0] rate);
    case (rate)
      2'h0:    byte_cycles = 16'(fbs_pkg::BYTE_CYC_250);
      2'h1:    byte_cycles = 16'(fbs_pkg::BYTE_CYC_500);
      2'h2:    byte_cycles = 16'(fbs_pkg::BYTE_CYC_1M);
      default: byte_cycles = 16'(fbs_pkg::BYTE_CYC_2M);
    endcase
  endfunction : byte_cycles

  function automatic logic is_listen(input fbs_pkg::fbs_mode_t m);
    is_listen = (m == fbs_pkg::MODE_RX) || (m == fbs_pkg::MODE_AACK);
  endfunction : is_listen

  fbs_mem_if mif ();
  fbs_mem u_mem (.clk(clk), .mp(mif));

  // Pin synchronisers: {pin, sclk, cs_n, mosi}
  // Preset to idle pin levels so no false edge or select follows reset
  logic [3:0] sync1_r, sync2_r, sync3_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      sync1_r <= 4'h2;
      sync2_r <= 4'h2;
      sync3_r <= 4'h2;
    end else begin
      sync1_r <= {sleep_transmit_pin, spi_sclk, spi_cs_n, spi_mosi};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end
  wire pin_rise_w = sync2_r[3] & ~sync3_r[3];
  wire sr_w       = sync2_r[2] & ~sync3_r[2];
  wire sf_w       = ~sync2_r[2] & sync3_r[2];
  wire cs_hi_w    = sync2_r[1];
  wire mosi_w     = sync2_r[0];

  // SPI byte assembly and command decode
  fbs_pkg::fbs_op_t op_r;
  logic [2:0] bitc_r;
  logic [6:0] rsh_r;
  logic [5:0] radr_r;
  logic [7:0] rd_idx_r, hw_cnt_r, rx_cnt_r;
  logic [1:0] rate_r;
  logic       ld_r, skip_r, rx_act_r;
  logic [6:0] tsh_r;

  wire       byte_stb_w = sr_w & ~cs_hi_w & (bitc_r == 3'h7);
  wire [7:0] byte_w     = {rsh_r, mosi_w};
  wire       cmd_w      = byte_stb_w & (op_r == fbs_pkg::OP_NONE);
  wire       rd_req_w   = byte_stb_w & ((op_r == fbs_pkg::OP_FB_RD) |
                          ((op_r == fbs_pkg::OP_NONE) & (byte_w == fbs_pkg::CMD_FB_RD)));
  wire [7:0] rd_at_w    = (op_r == fbs_pkg::OP_NONE) ? 8'h00 : rd_idx_r;
  wire       ur_rd_w    = rd_req_w & rx_act_r & (rd_at_w >= rx_cnt_r);
  wire       reg_wr_w   = byte_stb_w & (op_r == fbs_pkg::OP_REG);
  wire       sc_stb_w   = reg_wr_w & (radr_r == fbs_pkg::REG_STATE_ADDR);
  wire [4:0] sc_val_w   = byte_w[fbs_pkg::STATE_CMD_LSB +: 5];
  wire       fbw_w      = byte_stb_w & (op_r == fbs_pkg::OP_FB_WR) &
                          (hw_cnt_r < 8'(fbs_pkg::FB_DEPTH));

  always_ff @(posedge clk) begin
    if (srst || cs_hi_w) begin
      op_r   <= fbs_pkg::OP_NONE;
      bitc_r <= 3'h0;
      rsh_r  <= 7'h00;
      radr_r <= 6'h00;
    end else if (sr_w) begin
      rsh_r  <= byte_w[6:0];
      bitc_r <= bitc_r + 3'h1;
      if (cmd_w) begin
        radr_r <= byte_w[5:0];
        if (byte_w[7:6] == fbs_pkg::CMD_REG_WR_TAG) op_r <= fbs_pkg::OP_REG;
        else if (byte_w == fbs_pkg::CMD_FB_RD)      op_r <= fbs_pkg::OP_FB_RD;
        else if (byte_w == fbs_pkg::CMD_FB_WR)      op_r <= fbs_pkg::OP_FB_WR;
        else                                        op_r <= fbs_pkg::OP_REG;
      end else if (reg_wr_w) begin
        radr_r <= radr_r + 6'h01;
      end
    end
  end

  // Host write count and read index; rate field
  always_ff @(posedge clk) begin
    if (srst) begin
      hw_cnt_r <= 8'h00;
      rd_idx_r <= 8'h00;
      rate_r   <= fbs_pkg::RATE_RST;
    end else begin
      if (cmd_w && byte_w == fbs_pkg::CMD_FB_WR) hw_cnt_r <= 8'h00;
      else if (fbw_w) hw_cnt_r <= hw_cnt_r + 8'h01;
      if (rd_req_w) rd_idx_r <= rd_at_w + 8'h01;
      if (reg_wr_w && radr_r == fbs_pkg::REG_RATE_ADDR) begin
        rate_r <= byte_w[fbs_pkg::RATE_LSB +: 2];
      end
    end
  end

  // MISO: load on fetch, shift on falling edges, skip the fall after a load
  always_ff @(posedge clk) begin
    if (srst || cs_hi_w) begin
      ld_r        <= 1'b0;
      skip_r      <= 1'b0;
      tsh_r       <= 7'h00;
      spi_miso    <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      spi_miso_oe <= 1'b1;
      ld_r        <= rd_req_w;
      if (ld_r) begin
        spi_miso <= mif.ra_data[7];
        tsh_r    <= mif.ra_data[6:0];
        skip_r   <= 1'b1;
      end else if (sf_w) begin
        if (skip_r) begin
          skip_r <= 1'b0;
        end else begin
          spi_miso <= tsh_r[6];
          tsh_r    <= {tsh_r[5:0], 1'b0};
        end
      end
    end
  end

  // Radio mode and transmit sequencing
  fbs_pkg::fbs_mode_t mode_r, mode_nxt;
  fbs_pkg::fbs_txph_t tx_ph_r, tx_ph_nxt;
  logic [15:0] tmr_r, tmr_nxt;
  logic [7:0]  tx_idx_r;
  logic [6:0]  len_r;
  logic        fetch_d_r;

  wire tx_idle_w  = (tx_ph_r == fbs_pkg::TX_IDLE);
  wire can_tx_w   = tx_idle_w & ~rx_act_r &
                    ((mode_r == fbs_pkg::MODE_PLL) | (mode_r == fbs_pkg::MODE_ARET));
  wire trig_w     = can_tx_w & (pin_rise_w | (sc_stb_w & (sc_val_w == fbs_pkg::SC_TX_START)));
  wire [7:0] total_w = {1'b0, len_r} + 8'h01;
  wire tmr_end_w  = (tmr_r == 16'h0000);
  wire fetch_w    = tmr_end_w & ((tx_ph_r == fbs_pkg::TX_SHR) |
                    ((tx_ph_r == fbs_pkg::TX_DATA) & (tx_idx_r != total_w)));
  wire tx_done_w  = tmr_end_w & (tx_ph_r == fbs_pkg::TX_DATA) & (tx_idx_r == total_w);
  wire ur_tx_w    = fetch_w & (tx_idx_r >= hw_cnt_r);

  always_comb begin
    mode_nxt = mode_r;
    if (sc_stb_w && tx_idle_w && !rx_act_r) begin
      case (sc_val_w)
        fbs_pkg::SC_OFF:  mode_nxt = fbs_pkg::MODE_OFF;
        fbs_pkg::SC_PLL:  mode_nxt = fbs_pkg::MODE_PLL;
        fbs_pkg::SC_RX:   mode_nxt = fbs_pkg::MODE_RX;
        fbs_pkg::SC_AACK: mode_nxt = fbs_pkg::MODE_AACK;
        fbs_pkg::SC_ARET: mode_nxt = fbs_pkg::MODE_ARET;
        default:          mode_nxt = mode_r;
      endcase
    end
  end

  always_comb begin
    tx_ph_nxt = tx_ph_r;
    tmr_nxt   = tmr_end_w ? 16'h0000 : tmr_r - 16'h0001;
    case (tx_ph_r)
      fbs_pkg::TX_IDLE: begin
        if (trig_w) begin
          tx_ph_nxt = fbs_pkg::TX_SETTLE;
          tmr_nxt   = 16'(fbs_pkg::SETTLE_CYC - 1);
        end
      end
      fbs_pkg::TX_SETTLE: begin
        if (tmr_end_w) begin
          tx_ph_nxt = fbs_pkg::TX_SHR;
          tmr_nxt   = 16'(SHR_CYC - 1);
        end
      end
      fbs_pkg::TX_SHR: begin
        if (tmr_end_w) begin
          tx_ph_nxt = fbs_pkg::TX_DATA;
          tmr_nxt   = byte_cycles(rate_r) - 16'h0001;
        end
      end
      fbs_pkg::TX_DATA: begin
        if (tx_done_w) tx_ph_nxt = fbs_pkg::TX_IDLE;
        else if (fetch_w) tmr_nxt = byte_cycles(rate_r) - 16'h0001;
      end
      default: tx_ph_nxt = fbs_pkg::TX_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mode_r        <= fbs_pkg::MODE_OFF;
      tx_ph_r       <= fbs_pkg::TX_IDLE;
      tmr_r         <= 16'h0000;
      tx_idx_r      <= 8'h00;
      len_r         <= 7'h00;
      fetch_d_r     <= 1'b0;
      tx_byte       <= 8'h00;
      tx_byte_valid <= 1'b0;
      tx_shr_active <= 1'b0;
    end else begin
      mode_r        <= mode_nxt;
      tx_ph_r       <= tx_ph_nxt;
      tmr_r         <= tmr_nxt;
      tx_shr_active <= (tx_ph_nxt == fbs_pkg::TX_SHR);
      fetch_d_r     <= fetch_w;
      tx_byte_valid <= fetch_d_r;
      if (trig_w) begin
        tx_idx_r <= 8'h00;
        len_r    <= 7'h00;
      end else if (fetch_w) begin
        tx_idx_r <= tx_idx_r + 8'h01;
      end
      if (fetch_d_r) begin
        tx_byte <= mif.rb_data;
        if (tx_idx_r == 8'h01) len_r <= mif.rb_data[6:0];
      end
    end
  end
  assign radio_mode = mode_r;

  // Receive path
  wire listen_w = is_listen(mode_r) & tx_idle_w;
  wire rx_go_w  = listen_w & ~rx_act_r & rx_frame_detect;
  wire rx_wr_w  = rx_act_r & rx_byte_valid & (rx_cnt_r < 8'(fbs_pkg::FB_DEPTH));
  wire rx_end_w = rx_act_r & rx_frame_end;

  always_ff @(posedge clk) begin
    if (srst) begin
      rx_act_r              <= 1'b0;
      rx_cnt_r              <= 8'h00;
      rx_start_event        <= 1'b0;
      frame_done_event      <= 1'b0;
      buffer_underrun_event <= 1'b0;
      fb_empty              <= 1'b0;
    end else begin
      if (rx_go_w) begin
        rx_act_r <= 1'b1;
        rx_cnt_r <= 8'h00;
      end else begin
        if (rx_end_w) rx_act_r <= 1'b0;
        if (rx_wr_w) rx_cnt_r <= rx_cnt_r + 8'h01;
      end
      rx_start_event        <= rx_go_w & rx_start_irq_en;
      frame_done_event      <= rx_end_w | tx_done_w;
      buffer_underrun_event <= ur_rd_w | ur_tx_w;
      fb_empty              <= rx_act_r & (rd_idx_r >= rx_cnt_r);
    end
  end

  // Buffer ports: received bytes win a write collision with the host
  assign mif.we      = rx_wr_w | fbw_w;
  assign mif.waddr   = rx_wr_w ? rx_cnt_r[6:0] : hw_cnt_r[6:0];
  assign mif.wdata   = rx_wr_w ? rx_byte : byte_w;
  assign mif.ra_addr = rd_at_w[6:0];
  assign mif.rb_addr = tx_idx_r[6:0];

  // Helper: cycles spent in the current transmit phase
  fbs_pkg::fbs_txph_t ph_prev_r;
  logic [15:0] age_r;
  wire  [15:0] age_w = (tx_ph_r != ph_prev_r) ? 16'h0000 : age_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      ph_prev_r <= fbs_pkg::TX_IDLE;
      age_r     <= 16'h0000;
    end else begin
      ph_prev_r <= tx_ph_r;
      age_r     <= age_w + 16'h0001;
    end
  end

  a_rx_start_gate:
    assert property (@(posedge clk) disable iff (srst)
      rx_start_event |-> $past(rx_frame_detect) && $past(rx_start_irq_en) && $past(listen_w))
    else $error("receive-start without enabled frame detect in listen");
  a_rx_done_pulse:
    assert property (@(posedge clk) disable iff (srst)
      (rx_act_r && rx_frame_end) |=> frame_done_event && !rx_act_r)
    else $error("frame end did not give frame-done");
  a_settle_len:
    assert property (@(posedge clk) disable iff (srst)
      (tx_ph_r == fbs_pkg::TX_SHR && $past(tx_ph_r) == fbs_pkg::TX_SETTLE)
        |-> $past(age_w) == 16'(fbs_pkg::SETTLE_CYC - 1))
    else $error("settle phase has wrong length");
  a_shr_len:
    assert property (@(posedge clk) disable iff (srst)
      (tx_ph_r == fbs_pkg::TX_DATA && $past(tx_ph_r) == fbs_pkg::TX_SHR)
        |-> $past(age_w) == 16'(SHR_CYC - 1) ##1 tx_byte_valid)
    else $error("header phase length or first byte fetch wrong");
  a_trig_start:
    assert property (@(posedge clk) disable iff (srst)
      trig_w |=> tx_ph_r == fbs_pkg::TX_SETTLE && !tx_shr_active ##1 tx_ph_r == fbs_pkg::TX_SETTLE)
    else $error("trigger did not start settling");
  a_tx_done_pulse:
    assert property (@(posedge clk) disable iff (srst)
      (tx_ph_r == fbs_pkg::TX_IDLE && $past(tx_ph_r) == fbs_pkg::TX_DATA) |-> frame_done_event)
    else $error("transmit end without frame-done");
  a_byte_pace:
    assert property (@(posedge clk) disable iff (srst)
      tx_byte_valid |=> !tx_byte_valid [*8])
    else $error("transmit bytes too close together");
  a_rd_underrun:
    assert property (@(posedge clk) disable iff (srst)
      (rd_req_w && rx_act_r && rd_at_w >= rx_cnt_r) |=> buffer_underrun_event)
    else $error("overtaking read not flagged");
  a_empty_flag:
    assert property (@(posedge clk) disable iff (srst)
      fb_empty |-> $past(rx_act_r) && $past(rd_idx_r) >= $past(rx_cnt_r))
    else $error("empty flag without pending receive");
  a_miso_release:
    assert property (@(posedge clk) disable iff (srst)
      cs_hi_w |=> !spi_miso_oe ##1 !spi_miso_oe || !cs_hi_w)
    else $error("miso driven with chip select high");
endmodule : fbs_seq

// [tb_top.sv]
// Self-checking bench for the frame buffer sequencer
`timescale 1ns/1ns
module tb_top;
  localparam int SHR_P = 400;
  typedef struct { logic [4:0] cmd; logic [2:0] mode; } fbs_row_t;
  fbs_row_t   rows [5] = '{'{fbs_pkg::SC_PLL, fbs_pkg::MODE_PLL},
                           '{fbs_pkg::SC_RX, fbs_pkg::MODE_RX},
                           '{fbs_pkg::SC_AACK, fbs_pkg::MODE_AACK},
                           '{fbs_pkg::SC_ARET, fbs_pkg::MODE_ARET},
                           '{fbs_pkg::SC_OFF, fbs_pkg::MODE_OFF}};
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic       spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
  logic       stp = 1'b0, irq_en = 1'b0, det = 1'b0, bv = 1'b0, fend = 1'b0;
  logic [7:0] rxb = 8'h00, tx_byte;
  logic       tx_byte_valid, tx_shr_active, rx_start_event, frame_done_event;
  logic       buffer_underrun_event, fb_empty;
  logic [2:0] radio_mode;
  int         num_errors = 0, checks_done = 0, cyc = 0, n_rxs = 0, n_done = 0;
  int         n_ur = 0, n_shr = 0, shr_st = 0, t0, b, u0, d0, r0, s0;
  logic [7:0] txq[$], wr[$], rd[8];
  int         txt[$];

  always #4 clk = ~clk;

  fbs_host_model i_fbs_host_model (.clk(clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe));

  fbs_seq #(.SHR_CYC(SHR_P)) i_fbs_seq (.clk(clk), .srst(srst), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe), .sleep_transmit_pin(stp), .rx_start_irq_en(irq_en),
    .rx_frame_detect(det), .rx_byte_valid(bv), .rx_byte(rxb), .rx_frame_end(fend),
    .tx_byte(tx_byte), .tx_byte_valid(tx_byte_valid), .tx_shr_active(tx_shr_active),
    .rx_start_event(rx_start_event), .frame_done_event(frame_done_event),
    .buffer_underrun_event(buffer_underrun_event), .fb_empty(fb_empty),
    .radio_mode(radio_mode));

  // Event counters and transmit byte log
  always @(posedge clk) begin
    cyc <= cyc + 1;
    n_rxs <= n_rxs + int'(rx_start_event === 1'b1);
    n_done <= n_done + int'(frame_done_event === 1'b1);
    n_ur <= n_ur + int'(buffer_underrun_event === 1'b1);
    n_shr <= n_shr + int'(tx_shr_active === 1'b1);
    if ($rose(tx_shr_active)) shr_st <= cyc;
    if (tx_byte_valid === 1'b1) begin
      txq.push_back(tx_byte);
      txt.push_back(cyc);
    end
  end

  task automatic tally_and_finish();
    $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic fb(input logic [7:0] cmd, input int n);
    i_fbs_host_model.sel(1'b1);
    i_fbs_host_model.xfer(cmd, rd[0]);
    for (int i = 0; i < n; i++) i_fbs_host_model.xfer(i < wr.size() ? wr[i] : 8'h00, rd[i]);
    i_fbs_host_model.sel(1'b0);
    repeat (10) @(negedge clk);
  endtask : fb

  task automatic reg_wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] keep[$];
    keep = wr;
    wr = '{d};
    fb({fbs_pkg::CMD_REG_WR_TAG, a}, 1);
    wr = keep;
  endtask : reg_wr

  task automatic rx_ev(input logic d, input logic v, input logic e, input logic [7:0] x);
    det = d;
    bv = v;
    fend = e;
    rxb = x;
    @(negedge clk);
    det = 1'b0;
    bv = 1'b0;
    fend = 1'b0;
    repeat (20) @(negedge clk);
  endtask : rx_ev

  task automatic trig(input logic pin);
    b = txq.size();
    d0 = n_done;
    u0 = n_ur;
    s0 = n_shr;
    t0 = cyc;
    if (pin) begin
      stp = 1'b1;
      repeat (20) @(negedge clk);
      stp = 1'b0;
    end else reg_wr(fbs_pkg::REG_STATE_ADDR, {3'h0, fbs_pkg::SC_TX_START});
  endtask : trig

  task automatic fin(input int nb, input int nu, input int per);
    for (int i = 0; i < 20000 && n_done == d0; i++) @(negedge clk);
    check(n_done - d0, 1);
    check(txq.size() - b, nb);
    check(n_ur - u0, nu);
    check(n_shr - s0, SHR_P);
    check(txt[b + 1] - txt[b], per);
    for (int i = 0; i < wr.size(); i++) check(txq[b + i], wr[i]);
  endtask : fin

  initial begin
    #400000;
    num_errors++;
    tally_and_finish();
  end

  initial begin
    repeat (10) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
    foreach (rows[i]) begin
      reg_wr(fbs_pkg::REG_STATE_ADDR, {3'h0, rows[i].cmd});
      check(radio_mode, rows[i].mode);
    end
    // Receive: event gated by enable, early read, overtaking read, late read
    reg_wr(fbs_pkg::REG_STATE_ADDR, {3'h0, fbs_pkg::SC_RX});
    r0 = n_rxs;
    d0 = n_done;
    rx_ev(1'b1, 1'b0, 1'b0, 8'h00);
    check(n_rxs - r0, 0);
    rx_ev(1'b0, 1'b0, 1'b1, 8'h00);
    check(n_done - d0, 1);
    irq_en = 1'b1;
    rx_ev(1'b1, 1'b0, 1'b0, 8'h00);
    check(n_rxs - r0, 1);
    check(fb_empty, 1'b1);
    for (int i = 0; i < 4; i++) rx_ev(1'b0, 1'b1, 1'b0, 8'hA0 + 8'(i));
    check(fb_empty, 1'b0);
    repeat (4000) @(negedge clk); // Wait 32 us before the first early fetch
    u0 = n_ur;
    wr = {};
    fb(fbs_pkg::CMD_FB_RD, 2);
    check({rd[0], rd[1]}, 16'hA0A1);
    check(n_ur - u0, 0);
    fb(fbs_pkg::CMD_FB_RD, 6);
    check(n_ur != u0, 1'b1);
    rx_ev(1'b0, 1'b0, 1'b1, 8'h00);
    check(n_done - d0, 2);
    u0 = n_ur;
    fb(fbs_pkg::CMD_FB_RD, 4);
    check({rd[0], rd[1], rd[2], rd[3]}, 32'hA0A1A2A3);
    check(n_ur - u0, 0);
    // Transmit start is refused outside the transmit-ready states
    s0 = n_shr;
    reg_wr(fbs_pkg::REG_STATE_ADDR, {3'h0, fbs_pkg::SC_TX_START});
    repeat (2500) @(negedge clk);
    check(n_shr - s0, 0);
    // Buffer written first, command trigger, fastest rate
    reg_wr(fbs_pkg::REG_RATE_ADDR, 8'h03);
    reg_wr(fbs_pkg::REG_STATE_ADDR, {3'h0, fbs_pkg::SC_PLL});
    wr = '{8'h02, 8'hA5, 8'h3C};
    fb(fbs_pkg::CMD_FB_WR, 3);
    trig(1'b0);
    fin(3, 0, fbs_pkg::BYTE_CYC_2M);
    // Pin trigger, buffer filled while the header goes out
    reg_wr(fbs_pkg::REG_STATE_ADDR, {3'h0, fbs_pkg::SC_ARET});
    trig(1'b1);
    for (int i = 0; i < 3000 && tx_shr_active !== 1'b1; i++) @(negedge clk);
    @(negedge clk);
    check((shr_st - t0) inside {[2000:2010]}, 1'b1);
    check(txq.size() - b, 0);
    wr = '{8'h01, 8'h5A};
    fb(fbs_pkg::CMD_FB_WR, 2);
    fin(2, 0, fbs_pkg::BYTE_CYC_2M);
    // Length promises more bytes than the host wrote, 1M rate
    reg_wr(fbs_pkg::REG_RATE_ADDR, 8'h02);
    reg_wr(fbs_pkg::REG_STATE_ADDR, {3'h0, fbs_pkg::SC_ARET});
    wr = '{8'h03, 8'h11};
    fb(fbs_pkg::CMD_FB_WR, 2);
    trig(1'b0);
    fin(4, 2, fbs_pkg::BYTE_CYC_1M);
    // Reset in mid-reception returns to off with no buffer indication
    reg_wr(fbs_pkg::REG_STATE_ADDR, {3'h0, fbs_pkg::SC_RX});
    rx_ev(1'b1, 1'b0, 1'b0, 8'h00);
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    repeat (3) @(negedge clk);
    check({radio_mode, fb_empty}, 4'h0);
    tally_and_finish();
  end
endmodule : tb_top
